/* File: design/nrb_pkg.sv */
// shared constants and types for the nand ready/protect/bad-block host sequencer
package nrb_pkg;

    localparam int unsigned CLK_MHZ        = 200;
    // power-on wait, in microseconds (5 ms)
    localparam int unsigned POR_WAIT_US    = 5000;
    localparam int unsigned POR_WAIT_CYC   = POR_WAIT_US * CLK_MHZ;
    // longest device reset, erasing case, in microseconds
    localparam int unsigned RST_MAX_US     = 500;
    localparam int unsigned RST_MAX_CYC    = RST_MAX_US * CLK_MHZ;
    // guard between command and first busy look (tWB), in ns
    localparam int unsigned TWB_NS         = 100;
    localparam int unsigned TWB_CYC        = (TWB_NS * CLK_MHZ + 999) / 1000;

    localparam int unsigned BLK_W          = 12;
    localparam int unsigned NUM_BLK        = 4096;
    localparam int unsigned BLK_PER_DIE    = 2048;
    localparam int unsigned MIN_GOOD_DIE   = 2008;
    localparam int unsigned SAFE_BLKS      = 8;

    localparam logic [7:0]  GOOD_MARK      = 8'hff;
    localparam logic [7:0]  STAT_FAIL_BIT  = 8'h01;
    localparam logic [11:0] CNT_RST        = 12'h000;

    typedef enum logic [1:0] {
        NRB_OP_READ,
        NRB_OP_PROG,
        NRB_OP_ERASE
    } nrb_op_t;

    typedef enum logic [3:0] {
        NRB_POR,
        NRB_SCAN_REQ,
        NRB_SCAN_WAIT,
        NRB_IDLE,
        NRB_CHECK,
        NRB_ISSUE,
        NRB_GUARD,
        NRB_BUSY,
        NRB_STATUS,
        NRB_DONE
    } nrb_state_t;

endpackage

/* File: design/nrb_bbt_mem.sv */
// bad block table: one flag bit per block, registered read
`timescale 1ns/1ps
`default_nettype none
module nrb_bbt_mem
    import nrb_pkg::*;
(
    // clock
    input  wire  logic             ref_clk,
    // write port
    input  wire  logic             wr_en,
    input  wire  logic [BLK_W-1:0] wr_addr,
    input  wire  logic             wr_bad,
    // read port
    input  wire  logic [BLK_W-1:0] rd_addr,
    output logic                   rd_bad
);
    logic mem_r [NUM_BLK];

    // no reset: scan rewrites every entry before use
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_bad;
        end
    end

    always_ff @(posedge ref_clk) begin
        rd_bad <= mem_r[rd_addr];
    end
endmodule
`default_nettype wire

/* File: design/nrb_host.sv */
// host sequencer: power-on wait, write-protect, bad block table, op failure handling
`timescale 1ns/1ps
`default_nettype none
module nrb_host
    import nrb_pkg::*;
#(
    parameter int unsigned POR_CYC = POR_WAIT_CYC,
    parameter int unsigned RST_CYC = RST_MAX_CYC
)(
    // clock and reset
    input  wire  logic             ref_clk,
    input  wire  logic             sys_rst,
    // power state
    input  wire  logic             pwr_good,
    // flash pins
    input  wire  logic             rb_in,
    output logic                   ce_n_r,
    output logic                   wp_n_r,
    // low-level flash engine: issues commands, reads markers and status
    output logic                   eng_req,
    output nrb_op_t                eng_op,
    output logic                   eng_mark_rd,
    output logic [BLK_W-1:0]       eng_blk,
    input  wire  logic             eng_ack,
    input  wire  logic [7:0]       eng_mark0,
    input  wire  logic [7:0]       eng_mark1,
    input  wire  logic [7:0]       eng_status,
    input  wire  logic             eng_ecc_fail,
    // user request
    input  wire  logic             usr_req,
    input  wire  nrb_op_t          usr_op,
    input  wire  logic [BLK_W-1:0] usr_blk,
    input  wire  logic             usr_abort,
    output logic                   usr_ready,
    output logic                   usr_done_r,
    output logic                   usr_fail_r,
    output logic                   usr_refused_r,
    output logic                   usr_timeout_r,
    // health
    output logic                   scan_done_r,
    output logic                   die_low_r,
    output logic [BLK_W-1:0]       bad_cnt0_r,
    output logic [BLK_W-1:0]       bad_cnt1_r
);
    nrb_state_t       st_r;
    logic [31:0]      tmr_r;
    logic [BLK_W-1:0] blk_r;
    nrb_op_t          op_r;
    logic             bbt_wr;
    logic             bbt_bad_wr;
    logic             rd_bad;
    logic [BLK_W-1:0] rd_addr;
    logic             blk_fail;
    logic             por_end;
    logic             fail_hold_r;

    // power-on wait over: device ready, or the full wait has run out
    assign por_end = pwr_good && (rb_in || tmr_r >= 32'(POR_CYC - 1));

    assign rd_addr   = (st_r == NRB_IDLE) ? usr_blk : blk_r;
    assign usr_ready = (st_r == NRB_IDLE);
    assign eng_blk   = blk_r;
    assign eng_op    = op_r;
    assign eng_req   = (st_r == NRB_SCAN_REQ) || (st_r == NRB_ISSUE);
    assign eng_mark_rd = (st_r == NRB_SCAN_REQ);

    // a block is bad unless both markers read erased; first eight trusted
    assign bbt_bad_wr = (blk_r >= BLK_W'(SAFE_BLKS)) &&
                        ((eng_mark0 != GOOD_MARK) || (eng_mark1 != GOOD_MARK));
    assign blk_fail   = (op_r == NRB_OP_READ) ? eng_ecc_fail
                                              : ((eng_status & STAT_FAIL_BIT) != 8'h00);
    assign bbt_wr     = ((st_r == NRB_SCAN_WAIT) && eng_ack) ||
                        ((st_r == NRB_STATUS) && eng_ack && blk_fail && (op_r != NRB_OP_READ));

    nrb_bbt_mem u_bbt (
        .ref_clk (ref_clk),
        .wr_en   (bbt_wr),
        .wr_addr (blk_r),
        .wr_bad  ((st_r == NRB_SCAN_WAIT) ? bbt_bad_wr : 1'b1),
        .rd_addr (rd_addr),
        .rd_bad  (rd_bad)
    );

    // main sequence
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r  <= NRB_POR;
            tmr_r <= 32'h0000_0000;
            blk_r <= CNT_RST;
            op_r  <= NRB_OP_READ;
        end else begin
            case (st_r)
                NRB_POR: begin
                    // no command until ready seen or full wait elapsed
                    if (!pwr_good) begin
                        tmr_r <= 32'h0000_0000;
                    end else if (por_end) begin
                        st_r  <= NRB_SCAN_REQ;
                        blk_r <= CNT_RST;
                    end else begin
                        tmr_r <= tmr_r + 32'h1;
                    end
                end
                NRB_SCAN_REQ: st_r <= NRB_SCAN_WAIT;
                NRB_SCAN_WAIT: begin
                    if (eng_ack) begin
                        if (blk_r == BLK_W'(NUM_BLK - 1)) begin
                            st_r <= NRB_IDLE;
                        end else begin
                            blk_r <= blk_r + BLK_W'(1);
                            st_r  <= NRB_SCAN_REQ;
                        end
                    end
                end
                NRB_IDLE: begin
                    if (usr_req) begin
                        blk_r <= usr_blk;
                        op_r  <= usr_op;
                        st_r  <= NRB_CHECK;
                    end
                end
                NRB_CHECK: begin
                    // table read lands this cycle
                    st_r <= rd_bad ? NRB_DONE : NRB_ISSUE;
                end
                NRB_ISSUE: begin
                    tmr_r <= 32'h0000_0000;
                    st_r  <= NRB_GUARD;
                end
                NRB_GUARD: begin
                    // ready reads stale until the device goes busy
                    if (tmr_r >= 32'(TWB_CYC - 1)) begin
                        tmr_r <= 32'h0000_0000;
                        st_r  <= NRB_BUSY;
                    end else begin
                        tmr_r <= tmr_r + 32'h1;
                    end
                end
                NRB_BUSY: begin
                    if (rb_in || usr_abort || tmr_r >= 32'(RST_CYC - 1)) begin
                        st_r <= NRB_STATUS;
                    end else begin
                        tmr_r <= tmr_r + 32'h1;
                    end
                end
                NRB_STATUS: if (eng_ack) st_r <= NRB_DONE;
                NRB_DONE: st_r <= NRB_IDLE;
                default: st_r <= NRB_POR;
            endcase
        end
    end

    // pins: deselected until the power-on wait ends, protected except while an operation is issued, guarded or busy
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ce_n_r <= 1'b1;
            wp_n_r <= 1'b0;
        end else begin
            // select together with the first scan request, not a cycle after it
            ce_n_r <= !pwr_good || ((st_r == NRB_POR) && !por_end);
            // abort drops protect so the device resets the operation
            wp_n_r <= pwr_good && (st_r != NRB_POR) && !usr_abort &&
                      (st_r == NRB_ISSUE || st_r == NRB_GUARD || st_r == NRB_BUSY);
        end
    end

    // user result flags, one-cycle pulses
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            usr_done_r    <= 1'b0;
            usr_fail_r    <= 1'b0;
            usr_refused_r <= 1'b0;
            usr_timeout_r <= 1'b0;
            fail_hold_r   <= 1'b0;
        end else begin
            usr_done_r    <= (st_r == NRB_DONE);
            usr_refused_r <= (st_r == NRB_CHECK) && rd_bad;
            if (st_r == NRB_STATUS && eng_ack) begin
                fail_hold_r <= blk_fail;
            end else if (st_r == NRB_CHECK) begin
                fail_hold_r <= 1'b0;
            end
            // failure shows in the same cycle as done, never before it
            usr_fail_r    <= (st_r == NRB_DONE) && fail_hold_r;
            usr_timeout_r <= (st_r == NRB_BUSY) && !rb_in && !usr_abort &&
                             (tmr_r >= 32'(RST_CYC - 1));
        end
    end

    // bad block counts per die, for the lifetime floor
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bad_cnt0_r  <= CNT_RST;
            bad_cnt1_r  <= CNT_RST;
            scan_done_r <= 1'b0;
            die_low_r   <= 1'b0;
        end else begin
            if (bbt_wr && ((st_r != NRB_SCAN_WAIT) || bbt_bad_wr)) begin
                if (blk_r < BLK_W'(BLK_PER_DIE)) begin
                    bad_cnt0_r <= bad_cnt0_r + BLK_W'(1);
                end else begin
                    bad_cnt1_r <= bad_cnt1_r + BLK_W'(1);
                end
            end
            if (st_r == NRB_SCAN_WAIT && eng_ack && blk_r == BLK_W'(NUM_BLK - 1)) begin
                scan_done_r <= 1'b1;
            end
            // counts never repeat a block: a tabled block is refused before it can fail again
            die_low_r <= (bad_cnt0_r > BLK_W'(BLK_PER_DIE - MIN_GOOD_DIE)) ||
                         (bad_cnt1_r > BLK_W'(BLK_PER_DIE - MIN_GOOD_DIE));
        end
    end
endmodule
`default_nettype wire

/* File: bench/nrb_host_chk_sva.sv */
// port assertions for the host sequencer
`timescale 1ns/1ps
`default_nettype none
module nrb_host_chk
    import nrb_pkg::*;
#(
    parameter int unsigned POR_CYC = 50,
    parameter int unsigned RST_CYC = 40
)(
    // clock, reset, power
    input wire logic             ref_clk,
    input wire logic             sys_rst,
    input wire logic             pwr_good,
    // flash side
    input wire logic             ce_n_r,
    input wire logic             wp_n_r,
    input wire logic             eng_req,
    input wire logic             eng_mark_rd,
    // user and health side
    input wire logic             usr_ready,
    input wire logic             usr_done_r,
    input wire logic             usr_fail_r,
    input wire logic             usr_refused_r,
    input wire logic             scan_done_r,
    input wire logic             die_low_r,
    input wire logic [BLK_W-1:0] bad_cnt0_r,
    input wire logic [BLK_W-1:0] bad_cnt1_r
);
    localparam int POR_LIM = POR_CYC + 4;
    localparam int SPARE = BLK_PER_DIE - MIN_GOOD_DIE;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wp_power_a: assert property (!pwr_good |-> !wp_n_r)
        else $error("write protect released without power");
    ce_power_a: assert property (!pwr_good |-> ce_n_r)
        else $error("chip enabled without power");
    por_quiet_a: assert property ($rose(pwr_good) |-> !eng_req [*8])
        else $error("request during power-on reset");
    por_end_a: assert property ($rose(pwr_good) |-> ##[1:POR_LIM] eng_req)
        else $error("power-on wait too long");
    op_scan_a: assert property (eng_req && !eng_mark_rd |-> scan_done_r)
        else $error("operation before marker scan");
    wp_op_a: assert property (eng_req && !eng_mark_rd |-> ##[1:2] wp_n_r)
        else $error("write protect not released for operation");
    refuse_done_a: assert property (usr_refused_r |-> !eng_req ##1 usr_done_r)
        else $error("refused request reached the flash");
    fail_done_a: assert property (usr_fail_r |-> usr_done_r)
        else $error("failure flag without done");
    die_low_a: assert property ($stable(bad_cnt0_r) && $stable(bad_cnt1_r) ##1
        $stable(bad_cnt0_r) && $stable(bad_cnt1_r) |-> die_low_r == (bad_cnt0_r > SPARE || bad_cnt1_r > SPARE))
        else $error("die low flag disagrees with counts");
endmodule
bind nrb_host nrb_host_chk #(.POR_CYC(POR_CYC), .RST_CYC(RST_CYC)) i_nrb_host_chk (.*);
`default_nettype wire

/* File: bench/nrb_flash_model.sv */
// behavioural flash device behind the sequencer's engine port
`timescale 1ns/1ps
`default_nettype none
module nrb_flash_model
    import nrb_pkg::*;
#(
    parameter int POR_BUSY = 30
)(
    // host side
    input wire logic             ref_clk,
    input wire logic             pwr_good,
    input wire logic             ce_n_r,
    input wire logic             wp_n_r,
    input wire logic             eng_req,
    input wire logic             eng_mark_rd,
    input wire nrb_op_t          eng_op,
    input wire logic [BLK_W-1:0] eng_blk,
    // device answers
    output logic                 rb_in,
    output logic                 eng_ack,
    output logic [7:0]           eng_mark0,
    output logic [7:0]           eng_mark1,
    output logic [7:0]           eng_status,
    output logic                 eng_ecc_fail
);
    int   por_cnt, busy, age;
    logic pend, bad_st, wr_op;
    always_ff @(posedge ref_clk) begin
        eng_ack    <= 1'b0;
        pend       <= 1'b0;
        // undriven marker and status answers move every cycle so stale data never looks valid
        eng_mark0  <= ~eng_mark0;
        eng_mark1  <= ~eng_mark1;
        eng_status <= ~eng_status;
        if (!pwr_good) begin
            por_cnt    <= 0;
            busy       <= 0;
            rb_in      <= 1'b0;
            eng_mark0  <= 8'h5a;
            eng_mark1  <= 8'h3c;
            eng_status <= 8'h96;
        end else if (por_cnt < POR_BUSY) begin
            por_cnt <= por_cnt + 1;
            if (por_cnt == POR_BUSY - 1) begin
                rb_in <= 1'b1;
            end
        end else if (pend) begin
            eng_ack      <= 1'b1;
            eng_status   <= {7'h70, bad_st && wr_op};
            eng_ecc_fail <= bad_st && !wr_op;
        end else if (busy > 0) begin
            age  <= age + 1;
            busy <= busy - 1;
            // write protect only counts once the engine has had time to raise it
            if (busy == 1 || (wr_op && age > 2 && !wp_n_r)) begin
                busy   <= 0;
                rb_in  <= 1'b1;
                pend   <= 1'b1;
                bad_st <= bad_st || busy != 1;
            end
        end else if (eng_req && !ce_n_r) begin
            if (eng_mark_rd) begin
                eng_ack   <= 1'b1;
                eng_mark0 <= (eng_blk > 7 && eng_blk[8:0] == 9'h009) ? 8'h00 : GOOD_MARK;
                eng_mark1 <= (eng_blk > 7 && eng_blk[8:0] inside {9'h009, 9'h011}) ? 8'h00 : GOOD_MARK;
            end else begin
                busy   <= 24 + eng_blk[3:0];
                age    <= 0;
                rb_in  <= 1'b0;
                wr_op  <= eng_op != NRB_OP_READ;
                bad_st <= eng_blk[1:0] == 2'b11;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/nrb_host_bench.sv */
// testbench: host sequencer against the flash model and a table-based reference
`timescale 1ns/1ps
`default_nettype none
module nrb_host_bench
    import nrb_pkg::*;
;
    logic             ref_clk = 0, sys_rst = 1, pwr_good = 0, usr_req = 0, usr_abort = 0;
    logic             rb_in, ce_n_r, wp_n_r, eng_req, eng_mark_rd, eng_ack, eng_ecc_fail, usr_ready;
    logic             usr_done_r, usr_fail_r, usr_refused_r, usr_timeout_r, scan_done_r, die_low_r;
    logic [7:0]       eng_mark0, eng_mark1, eng_status;
    logic [BLK_W-1:0] eng_blk, usr_blk, bad_cnt0_r, bad_cnt1_r;
    nrb_op_t          eng_op, usr_op;
    int               err_count, checks_done, seed, n0, n1;
    bit               bad_tab [int];
    int               d_op [9] = '{1, 2, 0, 2, 0, 0, 2, 1, 0};
    int               d_blk [9] = '{11, 11, 9, 17, 15, 15, 2055, 2055, 4};
    always #2.5 ref_clk = ~ref_clk;
    nrb_host #(.POR_CYC(50), .RST_CYC(40)) i_nrb_host (.*);
    nrb_flash_model i_nrb_flash_model (.*);
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // abrt: an aborted write reads back a failed status and is tabled
    task automatic do_op(input nrb_op_t op, input int blk, input bit abrt);
        logic ref_s, fail_s, to_s, done_s, exp_ref, exp_fail;
        exp_ref = bad_tab.exists(blk);
        ref_s = 0;
        to_s = 0;
        done_s = 0;
        for (int i = 0; i < 100 && usr_ready !== 1'b1; i++) @(negedge ref_clk);
        usr_req = 1;
        usr_op = op;
        usr_blk = blk[BLK_W-1:0];
        @(negedge ref_clk);
        usr_req = 0;
        for (int i = 0; i < 200 && done_s !== 1'b1; i++) begin
            ref_s |= usr_refused_r;
            to_s |= usr_timeout_r;
            fail_s = usr_fail_r;
            done_s = usr_done_r;
            if (done_s !== 1'b1) @(negedge ref_clk);
        end
        chk("done", done_s, 1);
        chk("refused", ref_s, exp_ref);
        chk("timeout", to_s, 0);
        exp_fail = abrt ? (op != NRB_OP_READ) : (blk[1:0] == 2'b11);
        if (!exp_ref) begin
            chk("fail", fail_s, exp_fail);
            if (exp_fail && op != NRB_OP_READ) bad_tab[blk] = 1;
        end
    endtask
    initial begin
        seed = 32'hbb92d492;
        usr_op = NRB_OP_READ;
        usr_blk = '0;
        err_count = 0;
        checks_done = 0;
        repeat (5) @(negedge ref_clk);
        sys_rst = 0;
        repeat (10) @(negedge ref_clk);
        pwr_good = 1;
        for (int i = 0; i < 20000 && usr_ready !== 1'b1; i++) @(negedge ref_clk);
        chk("scan_done", scan_done_r, 1);
        chk("bad_cnt0", bad_cnt0_r, 8);
        chk("bad_cnt1", bad_cnt1_r, 8);
        chk("die_low", die_low_r, 0);
        for (int b = 8; b < NUM_BLK; b++) if (b % 512 == 9 || b % 512 == 17) bad_tab[b] = 1;
        for (int i = 0; i < 9; i++) do_op(nrb_op_t'(d_op[i]), d_blk[i], 0);
        fork
            do_op(NRB_OP_ERASE, 28, 1);
            begin
                repeat (25) @(negedge ref_clk);
                usr_abort = 1;
                repeat (2) @(negedge ref_clk);
                usr_abort = 0;
            end
        join
        for (int i = 0; i < 24; i++) do_op(nrb_op_t'(i % 3), 8 + {$random(seed)} % 4088, 0);
        foreach (bad_tab[b]) begin
            if (b < BLK_PER_DIE) n0++;
            else n1++;
        end
        chk("bad_cnt0_end", bad_cnt0_r, n0[15:0]);
        chk("bad_cnt1_end", bad_cnt1_r, n1[15:0]);
        chk("die_low_end", die_low_r, 0);
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge ref_clk);
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
